// ===== design/smc_pkg.sv
/*
 * Shared constants for the standby mode controller: settling-select
 * register address, reset value, field layout, settling counts and the
 * wake-up latency figures.
 * Assumes a single 100 MHz core clock standing in for the system clock.
 */
package smc_pkg;
	localparam logic [15:0] OSC_SETTLE_SELECT_ADDR = 16'hFFFA;
	localparam logic [7:0] OSC_SETTLE_RESET = 8'h04;
	localparam logic [7:0] OSC_SETTLE_WMASK = 8'h07;
	localparam logic [2:0] SEL_2P12 = 3'h0;
	localparam logic [2:0] SEL_2P15 = 3'h2;
	localparam logic [2:0] SEL_2P17 = 3'h4;
	localparam int CNT_W = 18;
	// settling counts in system clock periods
	localparam logic [CNT_W-1:0] SETTLE_2P12 = 18'h01000;
	localparam logic [CNT_W-1:0] SETTLE_2P15 = 18'h08000;
	localparam logic [CNT_W-1:0] SETTLE_2P17 = 18'h20000;
	// wake latency in clocks: vectored 9..10, plain resume 1..2
	localparam logic [3:0] WAKE_VECT = 4'h9;
	localparam logic [3:0] WAKE_PLAIN = 4'h1;
	// oscillator start-up delay, not part of the counted wait
	localparam logic [7:0] OSC_START_CYC = 8'h10;
	typedef enum logic [1:0] {SMC_CMD_NONE, SMC_CMD_HALT, SMC_CMD_STOP}
		smc_cmd_t;
	typedef enum logic [1:0] {SMC_RES_NEXT, SMC_RES_VECTOR, SMC_RES_RESET}
		smc_res_t;
endpackage : smc_pkg

// ===== design/smc_link_if.sv
/*
 * Link between the standby controller and the CPU / interrupt logic.
 * Assumes both ends share core_clk; no clocking block.
 */
`timescale 1ns/100ps
`default_nettype none
interface smc_link_if;
	logic cmd_valid;
	smc_pkg::smc_cmd_t cmd;
	logic mask_irq_pend;
	logic nmi_req;
	logic irq_accept_enable;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic cpu_clk_en;
	logic osc_run;
	logic periph_clk_en;
	logic resume_valid;
	smc_pkg::smc_res_t resume_kind;
	modport ctrl (
		input cmd_valid, cmd, mask_irq_pend, nmi_req, irq_accept_enable,
		input reg_wr, reg_rd, reg_addr, reg_wdata,
		output reg_rdata, cpu_clk_en, osc_run, periph_clk_en,
		output resume_valid, resume_kind
	);
	modport core (
		output cmd_valid, cmd, mask_irq_pend, nmi_req, irq_accept_enable,
		output reg_wr, reg_rd, reg_addr, reg_wdata,
		input reg_rdata, cpu_clk_en, osc_run, periph_clk_en,
		input resume_valid, resume_kind
	);
endinterface : smc_link_if
`default_nettype wire

// ===== design/smc_settle_counter.sv
/*
 * Oscillation settling counter: loads a target, counts core_clk periods
 * while enabled, pulses done when the target is reached.
 * Assumes start is a one-cycle pulse given once the oscillator runs.
 */
`timescale 1ns/100ps
`default_nettype none
module smc_settle_counter (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [smc_pkg::CNT_W-1:0] target,
	output logic busy,
	output logic done
);
	logic [smc_pkg::CNT_W-1:0] cnt;
	logic [smc_pkg::CNT_W-1:0] next_cnt;
	logic next_busy;
	logic next_done;

	always_comb
	begin
		next_cnt = cnt;
		next_busy = busy;
		next_done = 1'b0;
		if (start)
		begin
			next_cnt = target - 18'h00001;
			next_busy = 1'b1;
		end
		else if (busy)
		begin
			if (cnt == '0)
			begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			else
				next_cnt = cnt - 18'h00001;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end
endmodule : smc_settle_counter
`default_nettype wire

// ===== design/smc_standby_ctrl.sv
/*
 * Standby mode controller, device end: HALT and STOP states, clock gating,
 * settling-select register and wake-up sequencing.
 * Assumes the CPU end presents commands and wake requests on smc_link_if
 * synchronous to core_clk, and that its own state is frozen while
 * cpu_clk_en is low.
 */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - HALT gates CPU clock, oscillator keeps running
// - STOP halts oscillator and whole system
// - standby preserves all state and latches
// - interrupt-released STOP waits selected settling time
// - reset loads settling select with 04H
// - wait after reset is always 2^12
// - codes 000/010/100 give 2^12/2^15/2^17
// - software writes select with 8-bit access
// - settling count starts at oscillation start
// - peripherals keep running during HALT
// - nvm write completes in HALT, unmask wake
// - unmasked maskable request releases HALT
// - HALT wake latency 9-10 or 1-2
// - non-maskable request releases HALT, vectored
// - software stops peripherals before STOP
// - reset during HALT restarts at vector
// - STOP wake then vector or next
// - pending request at STOP drops to HALT
// - reset-released STOP runs reset after wait
module smc_standby_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	smc_link_if.ctrl link,
	output logic in_halt,
	output logic in_stop,
	output logic [2:0] settle_code
);
	typedef enum {
		SMC_RUN, SMC_HALT, SMC_STOP, SMC_OSC_START, SMC_SETTLE, SMC_WAKE
	} smc_state_t;

	// ****************************************************
	// settling-select register
	// ****************************************************
	logic [7:0] osc_settle_select;
	logic [7:0] next_sel;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic sel_hit;

	assign sel_hit = link.reg_addr == smc_pkg::OSC_SETTLE_SELECT_ADDR;

	always_comb
	begin
		next_sel = osc_settle_select;
		next_rdata = rdata;
		if (link.reg_wr && sel_hit)
			next_sel = link.reg_wdata & smc_pkg::OSC_SETTLE_WMASK;
		if (link.reg_rd)
			next_rdata = sel_hit ? osc_settle_select : 8'h00;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			osc_settle_select <= smc_pkg::OSC_SETTLE_RESET;
			rdata <= 8'h00;
		end
		else
		begin
			osc_settle_select <= next_sel;
			rdata <= next_rdata;
		end
	end

	assign link.reg_rdata = rdata;
	assign settle_code = osc_settle_select[2:0];

	// ****************************************************
	// standby sequencer
	// ****************************************************
	smc_state_t state;
	smc_state_t next_state;
	logic from_reset;
	logic next_from_reset;
	logic vect;
	logic next_vect;
	logic [7:0] osc_cnt;
	logic [7:0] next_osc_cnt;
	logic [3:0] wake_cnt;
	logic [3:0] next_wake_cnt;
	logic [smc_pkg::CNT_W-1:0] target;
	logic settle_start;
	logic settle_busy;
	logic settle_done;
	logic resume_valid;
	logic next_resume_valid;
	smc_pkg::smc_res_t resume_kind;
	smc_pkg::smc_res_t next_resume_kind;
	logic wake_req;

	// masked requests never reach mask_irq_pend, so they keep standby
	assign wake_req = link.mask_irq_pend || link.nmi_req;

	always_comb
	begin
		if (from_reset)
			target = smc_pkg::SETTLE_2P12;
		else
		begin
			case (osc_settle_select[2:0])
				smc_pkg::SEL_2P15: target = smc_pkg::SETTLE_2P15;
				smc_pkg::SEL_2P17: target = smc_pkg::SETTLE_2P17;
				default: target = smc_pkg::SETTLE_2P12;
			endcase
		end
	end

	smc_settle_counter u_settle (
		.core_clk(core_clk),
		.rst(rst),
		.start(settle_start),
		.target(target),
		.busy(settle_busy),
		.done(settle_done)
	);

	always_comb
	begin
		next_state = state;
		next_from_reset = from_reset;
		next_vect = vect;
		next_osc_cnt = osc_cnt;
		next_wake_cnt = wake_cnt;
		next_resume_valid = 1'b0;
		next_resume_kind = resume_kind;
		settle_start = 1'b0;
		case (state)
			SMC_RUN:
			begin
				if (link.cmd_valid && link.cmd == smc_pkg::SMC_CMD_HALT)
					next_state = SMC_HALT;
				else if (link.cmd_valid && link.cmd == smc_pkg::SMC_CMD_STOP)
				begin
					next_from_reset = 1'b0;
					next_vect = link.nmi_req || link.irq_accept_enable;
					// a pending request turns STOP into HALT plus settling
					if (wake_req)
					begin
						next_state = SMC_SETTLE;
						settle_start = 1'b1;
					end
					else
						next_state = SMC_STOP;
				end
			end
			SMC_HALT:
			begin
				if (wake_req)
				begin
					next_vect = link.nmi_req || link.irq_accept_enable;
					next_wake_cnt = (link.nmi_req || link.irq_accept_enable) ?
						smc_pkg::WAKE_VECT : smc_pkg::WAKE_PLAIN;
					next_state = SMC_WAKE;
				end
			end
			SMC_STOP:
			begin
				if (wake_req)
				begin
					next_vect = link.nmi_req || link.irq_accept_enable;
					next_osc_cnt = smc_pkg::OSC_START_CYC;
					next_state = SMC_OSC_START;
				end
			end
			SMC_OSC_START:
			begin
				if (osc_cnt == 8'h00)
				begin
					settle_start = 1'b1;
					next_state = SMC_SETTLE;
				end
				else
					next_osc_cnt = osc_cnt - 8'h01;
			end
			SMC_SETTLE:
			begin
				if (settle_done)
				begin
					next_wake_cnt = smc_pkg::WAKE_PLAIN;
					next_state = SMC_WAKE;
				end
			end
			SMC_WAKE:
			begin
				if (wake_cnt <= 4'h1)
				begin
					next_resume_valid = 1'b1;
					if (from_reset)
						next_resume_kind = smc_pkg::SMC_RES_RESET;
					else if (vect)
						next_resume_kind = smc_pkg::SMC_RES_VECTOR;
					else
						next_resume_kind = smc_pkg::SMC_RES_NEXT;
					next_from_reset = 1'b0;
					next_state = SMC_RUN;
				end
				else
					next_wake_cnt = wake_cnt - 4'h1;
			end
			default: next_state = SMC_RUN;
		endcase
	end

	// reset starts from the oscillator-start phase with the fixed wait
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= SMC_OSC_START;
			from_reset <= 1'b1;
			vect <= 1'b0;
			osc_cnt <= smc_pkg::OSC_START_CYC;
			wake_cnt <= 4'h0;
			resume_valid <= 1'b0;
			resume_kind <= smc_pkg::SMC_RES_NEXT;
		end
		else
		begin
			state <= next_state;
			from_reset <= next_from_reset;
			vect <= next_vect;
			osc_cnt <= next_osc_cnt;
			wake_cnt <= next_wake_cnt;
			resume_valid <= next_resume_valid;
			resume_kind <= next_resume_kind;
		end
	end

	// ****************************************************
	// clock gating outputs
	// ****************************************************
	// gating only freezes clocks, so CPU state and latches hold
	assign link.cpu_clk_en = state == SMC_RUN;
	assign link.osc_run = state != SMC_STOP && state != SMC_OSC_START;
	// peripherals and nvm writes keep their clock in HALT
	assign link.periph_clk_en = link.osc_run;
	assign link.resume_valid = resume_valid;
	assign link.resume_kind = resume_kind;
	assign in_halt = state == SMC_HALT || state == SMC_SETTLE;
	assign in_stop = state == SMC_STOP || state == SMC_OSC_START;
endmodule : smc_standby_ctrl
`default_nettype wire

// ===== design/smc_cpu_end.sv
/*
 * CPU / interrupt end of the standby link: forwards standby commands,
 * masks the nvm write-done request and drives register accesses.
 * Assumes user-side requests are synchronous to core_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module smc_cpu_end (
	input wire logic core_clk,
	input wire logic rst,
	smc_link_if.core link,
	input wire logic halt_req,
	input wire logic stop_req,
	input wire logic other_irq_pend,
	input wire logic nvm_write_done_irq,
	input wire logic nvm_write_done_mask,
	input wire logic nmi,
	input wire logic irq_en,
	input wire logic wr_req,
	input wire logic rd_req,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic cpu_run,
	output logic resumed,
	output smc_pkg::smc_res_t resumed_kind
);
	logic rd_pend;
	logic next_rd_pend;
	logic [7:0] next_rd_data;

	// software stops peripherals before STOP; not checked here
	assign link.cmd_valid = (halt_req || stop_req) && link.cpu_clk_en;
	assign link.cmd = stop_req ? smc_pkg::SMC_CMD_STOP :
		(halt_req ? smc_pkg::SMC_CMD_HALT : smc_pkg::SMC_CMD_NONE);
	// nvm done wakes standby only while its mask is clear
	assign link.mask_irq_pend = other_irq_pend ||
		(nvm_write_done_irq && !nvm_write_done_mask);
	assign link.nmi_req = nmi;
	assign link.irq_accept_enable = irq_en;
	// only byte-wide writes exist on this path
	assign link.reg_wr = wr_req;
	assign link.reg_rd = rd_req;
	assign link.reg_addr = smc_pkg::OSC_SETTLE_SELECT_ADDR;
	assign link.reg_wdata = wr_data;
	assign cpu_run = link.cpu_clk_en;
	assign resumed = link.resume_valid;
	assign resumed_kind = link.resume_kind;

	always_comb
	begin
		next_rd_pend = rd_req;
		next_rd_data = rd_pend ? link.reg_rdata : rd_data;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rd_pend <= 1'b0;
			rd_data <= 8'h00;
		end
		else
		begin
			rd_pend <= next_rd_pend;
			rd_data <= next_rd_data;
		end
	end
endmodule : smc_cpu_end
`default_nettype wire

// ===== sim/smc_sva.sv
/* checker for the standby link: gating, wake latency, settling.
   assumes link signals sampled on core_clk, rst async high. */
`timescale 1ns/100ps
`default_nettype none
module smc_sva (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire smc_pkg::smc_cmd_t cmd,
	input wire logic mask_irq_pend,
	input wire logic nmi_req,
	input wire logic irq_accept_enable,
	input wire logic cpu_clk_en,
	input wire logic osc_run,
	input wire logic periph_clk_en,
	input wire logic resume_valid,
	input wire smc_pkg::smc_res_t resume_kind
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ****************
	// helper state
	// ****************
	logic go;
	logic halted;
	logic next_halted;
	logic pend_seen;
	logic next_pend_seen;
	int cnt;
	int next_cnt;
	assign go = cmd_valid && cpu_clk_en && !mask_irq_pend && !nmi_req;
	always_comb
	begin
		next_halted = halted;
		next_pend_seen = pend_seen;
		if (go && cmd == smc_pkg::SMC_CMD_HALT)
			next_halted = 1'b1;
		else if (resume_valid)
			next_halted = 1'b0;
		// a wake stays latched, so a request dropped later is not masked
		if (resume_valid)
			next_pend_seen = 1'b0;
		else if (halted && (mask_irq_pend || nmi_req))
			next_pend_seen = 1'b1;
		// saturates so a long run cannot wrap
		next_cnt = !osc_run ? 32'h0 : cnt + int'(cnt < 32'hFFFFF);
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			halted <= 1'b0;
			pend_seen <= 1'b0;
			cnt <= 0;
		end
		else
		begin
			halted <= next_halted;
			pend_seen <= next_pend_seen;
			cnt <= next_cnt;
		end
	end
	property p_halt;
		go && cmd == smc_pkg::SMC_CMD_HALT |=> !cpu_clk_en && osc_run;
	endproperty
	a_halt: assert property (p_halt) else $error("halt gating");
	property p_stop;
		go && cmd == smc_pkg::SMC_CMD_STOP |=> !cpu_clk_en && !osc_run;
	endproperty
	a_stop: assert property (p_stop) else $error("stop osc");
	property p_pend;
		cmd_valid && cpu_clk_en && cmd == smc_pkg::SMC_CMD_STOP &&
			mask_irq_pend |=> !cpu_clk_en && osc_run;
	endproperty
	a_pend: assert property (p_pend) else $error("stop pend");
	property p_periph;
		halted |-> osc_run && periph_clk_en;
	endproperty
	a_periph: assert property (p_periph) else $error("periph");
	property p_plain;
		halted && $rose(mask_irq_pend) && !irq_accept_enable && !nmi_req
			|-> ##[1:2] resume_valid && resume_kind == smc_pkg::SMC_RES_NEXT;
	endproperty
	a_plain: assert property (p_plain) else $error("plain");
	property p_vect;
		halted && $rose(mask_irq_pend) && irq_accept_enable && !nmi_req
			|-> ##[9:10] resume_valid &&
			resume_kind == smc_pkg::SMC_RES_VECTOR;
	endproperty
	a_vect: assert property (p_vect) else $error("vect");
	property p_nmi;
		halted && $rose(nmi_req) |-> ##[9:10] resume_valid &&
			resume_kind == smc_pkg::SMC_RES_VECTOR;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi");
	property p_mask;
		halted && !pend_seen && !mask_irq_pend && !nmi_req
			|=> !resume_valid && !cpu_clk_en;
	endproperty
	a_mask: assert property (p_mask) else $error("masked");
	property p_settle;
		resume_valid |-> cnt >= 4096;
	endproperty
	a_settle: assert property (p_settle) else $error("short");
	property p_rst;
		resume_valid && resume_kind == smc_pkg::SMC_RES_RESET |-> cnt <= 4130;
	endproperty
	a_rst: assert property (p_rst) else $error("rst wait");
endmodule : smc_sva
`default_nettype wire

// ===== sim/tb.sv
/* bench joining both link ends; drives the cpu user side.
   assumes 100 MHz core_clk, rst async high. */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic core_clk, rst, halt_req, stop_req, other_irq_pend, nvm_irq;
	logic nvm_mask, nmi, irq_en, wr_req, rd_req, cpu_run, resumed;
	logic in_halt, in_stop;
	logic [7:0] wr_data, rd_data, d;
	logic [2:0] settle_code, code;
	smc_pkg::smc_res_t resumed_kind;
	int n_mismatch, n_tests, cyc, lat, i, s;
	smc_link_if i_smc_link_if ();
	smc_standby_ctrl i_smc_standby_ctrl (.core_clk, .rst,
		.link(i_smc_link_if.ctrl), .in_halt, .in_stop, .settle_code);
	smc_cpu_end i_smc_cpu_end (.core_clk, .rst, .link(i_smc_link_if.core),
		.halt_req, .stop_req, .other_irq_pend, .nvm_write_done_irq(nvm_irq),
		.nvm_write_done_mask(nvm_mask), .nmi, .irq_en, .wr_req, .rd_req,
		.wr_data, .rd_data, .cpu_run, .resumed, .resumed_kind);
	smc_sva i_smc_sva (.core_clk, .rst,
		.cmd_valid(i_smc_link_if.cmd_valid), .cmd(i_smc_link_if.cmd),
		.mask_irq_pend(i_smc_link_if.mask_irq_pend),
		.nmi_req(i_smc_link_if.nmi_req),
		.irq_accept_enable(i_smc_link_if.irq_accept_enable),
		.cpu_clk_en(i_smc_link_if.cpu_clk_en),
		.osc_run(i_smc_link_if.osc_run),
		.periph_clk_en(i_smc_link_if.periph_clk_en),
		.resume_valid(i_smc_link_if.resume_valid),
		.resume_kind(i_smc_link_if.resume_kind));
	// ****************
	// tasks
	// ****************
	task automatic complete_run;
		$display("mismatches %0d tests %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic bad(input string m);
		n_mismatch++;
		$display("wrong value at %0t: %s", $time, m);
	endtask : bad
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
			bad("byte");
	endtask : cmp8
	task automatic cmp1(input logic g, input logic e);
		n_tests++;
		if (g !== e)
			bad("flag");
	endtask : cmp1
	task automatic cmp_res(input smc_pkg::smc_res_t g, e);
		n_tests++;
		if (g !== e)
			bad("resume kind");
	endtask : cmp_res
	task automatic cmp_in(input int g, input int lo, input int hi);
		n_tests++;
		if (g < lo || g > hi)
			bad("latency");
	endtask : cmp_in
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	task automatic wait_res(input int lim);
		lat = 0;
		while (resumed !== 1'b1 && lat < lim)
		begin
			tick(1);
			lat++;
		end
	endtask : wait_res
	// settling wait in clocks for a select code; reserved codes act as 2^12
	function automatic int settle_of(input logic [2:0] c);
		if (c == smc_pkg::SEL_2P15)
			return 2 ** 15;
		if (c == smc_pkg::SEL_2P17)
			return 2 ** 17;
		return 2 ** 12;
	endfunction : settle_of
	task automatic rst_seq;
		rst = 1'b1;
		tick(8);
		rst = 1'b0;
		wait_res(4200);
		cmp_res(resumed_kind, smc_pkg::SMC_RES_RESET);
		cmp_in(lat, 4096 + 16, 4130);
		tick(2);
	endtask : rst_seq
	task automatic reg_wr(input logic [7:0] v);
		wr_data = v;
		wr_req = 1'b1;
		tick(1);
		wr_req = 1'b0;
	endtask : reg_wr
	task automatic reg_chk(input logic [7:0] e);
		rd_req = 1'b1;
		tick(1);
		rd_req = 1'b0;
		tick(3);
		cmp8(rd_data, e);
		cmp8({5'h0, settle_code}, e);
	endtask : reg_chk
	task automatic enter(input logic stop);
		halt_req = !stop;
		stop_req = stop;
		tick(1);
		halt_req = 1'b0;
		stop_req = 1'b0;
		tick(2);
		cmp1(cpu_run, 1'b0);
	endtask : enter
	// ****************
	// sequence
	// ****************
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = !core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc++;
		// sized for about 50k cycles of traffic
		if (cyc == 60000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	initial
	begin
		{halt_req, stop_req, other_irq_pend, nvm_irq, nmi, irq_en} = 6'h0;
		{wr_req, rd_req, wr_data, nvm_mask} = 11'h1;
		{n_mismatch, n_tests, cyc} = 0;
		i = $urandom(32'h1CA4);
		rst_seq();
		reg_chk(8'h04);
		for (i = 0; i < 6; i++)
		begin
			code = 3'(2 * (i % 3));
			d = i == 0 ? 8'hF8 : {5'($urandom), code};
			reg_wr(d);
			reg_chk({5'h0, code});
		end
		for (i = 0; i < 3; i++)
		begin
			irq_en = i == 1;
			enter(1'b0);
			cmp1(in_halt, 1'b1);
			cmp1(i_smc_link_if.osc_run, 1'b1);
			cmp1(i_smc_link_if.periph_clk_en, 1'b1);
			tick($urandom_range(1, 20));
			nmi = i == 2;
			other_irq_pend = i != 2;
			wait_res(30);
			cmp_res(resumed_kind, i == 0 ? smc_pkg::SMC_RES_NEXT :
				smc_pkg::SMC_RES_VECTOR);
			cmp_in(lat, i == 0 ? 1 : 9, i == 0 ? 4 : 13);
			{nmi, other_irq_pend} = 2'h0;
			tick(2);
		end
		irq_en = 1'b0;
		enter(1'b0);
		nvm_irq = 1'b1;
		tick(20);
		cmp1(cpu_run, 1'b0);
		nvm_mask = 1'b0;
		wait_res(30);
		cmp_in(lat, 1, 4);
		cmp_res(resumed_kind, smc_pkg::SMC_RES_NEXT);
		{nvm_irq, nvm_mask} = 2'h1;
		for (i = 0; i < 2; i++)
		begin
			code = 3'(2 * i);
			s = settle_of(code);
			reg_wr({5'h0, code});
			enter(1'b1);
			cmp1(in_stop, 1'b1);
			cmp1(i_smc_link_if.osc_run, 1'b0);
			tick($urandom_range(1, 20));
			irq_en = 1'($urandom);
			other_irq_pend = 1'b1;
			wait_res(s + 100);
			cmp_in(lat, s + 16, s + 32);
			cmp_res(resumed_kind, irq_en ? smc_pkg::SMC_RES_VECTOR :
				smc_pkg::SMC_RES_NEXT);
			other_irq_pend = 1'b0;
			tick(2);
		end
		// the pending-request wait follows the select code, so set 2^12
		reg_wr(8'h00);
		irq_en = 1'b0;
		other_irq_pend = 1'b1;
		enter(1'b1);
		cmp1(in_halt, 1'b1);
		cmp1(i_smc_link_if.osc_run, 1'b1);
		wait_res(4200);
		cmp_in(lat, 4000, 4120);
		cmp_res(resumed_kind, smc_pkg::SMC_RES_NEXT);
		other_irq_pend = 1'b0;
		tick(2);
		reg_wr(8'h02);
		enter(1'b0);
		rst_seq();
		reg_chk(8'h04);
		complete_run();
	end
endmodule : tb
`default_nettype wire
